// >>> rtl/relay_mux_pkg.sv
// Purpose: Shared constants and types for the relay mux self-test and reset block
// Assumes: Six sections of ten four-wire inputs, one relay board under control
// Notes: Relay state vector packs paths, common joins and one-wire paths
package relay_mux_pkg;

  // Switch matrix geometry
  localparam int NUM_SECT = 6;
  localparam int NUM_CHAN = 10;
  localparam int NUM_JOIN = NUM_SECT - 1;
  localparam int PATH_W = NUM_SECT * NUM_CHAN;
  localparam int SECT_W = 3;
  localparam int CHAN_W = 4;

  // Packed relay state layout
  localparam int PATH_LSB = 0;
  localparam int JOIN_LSB = PATH_LSB + PATH_W;
  localparam int OWP_LSB = JOIN_LSB + NUM_JOIN;
  localparam int REL_W = OWP_LSB + NUM_SECT;

  // Reset values
  localparam logic [REL_W-1:0] REL_RESET = {REL_W{1'b0}};
  localparam logic [NUM_SECT-1:0] CFG_RESET = {NUM_SECT{1'b0}};

  // Default width of the failure record (interface board plus relay board)
  localparam int DEF_FAIL_W = 2;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_IF = 3'h2,
    ST_INST = 3'h4
  } seq_state_t;

  // Routing operations
  typedef enum logic [2:0] {
    OP_CLOSE = 3'h0,
    OP_OPEN_ALL = 3'h1,
    OP_JOIN = 3'h2,
    OP_DISJOIN = 3'h3,
    OP_ONE_WIRE_CFG = 3'h4
  } route_op_t;

endpackage

// >>> rtl/in_sync3.sv
// Purpose: Three-stage synchroniser for a pin input with agreement filter
// Assumes: Input is asynchronous to clk
// Notes: Output changes only once stages two and three agree
`timescale 1ns/1ps
module in_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pin and result
  input wire logic async_in,
  output logic sync_out
);

  logic [2:0] stage_reg; // Shift chain, bit 0 sees the pin
  logic [2:0] stage_next;
  logic out_reg; // Filtered level
  logic out_next;

  // Next values; stage 0 feeds only stage 1
  always_comb begin
    stage_next = {stage_reg[1:0], async_in};
    out_next = out_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      out_next = stage_reg[2];
    end
  end

  // Registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_reg <= {3{RESET_VAL}};
      out_reg <= RESET_VAL;
    end else begin
      stage_reg <= stage_next;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule // in_sync3

// >>> rtl/relay_mux_self_test_reset.sv
// Purpose: Self-test sequencing, failure line control and relay routing state
// Assumes: Test engines and the commander are logic on CLK
// Notes: Reset and supply pin inputs pass through in_sync3; SYSFAIL_IN is not used
// Notes on behaviour
// - Start test on power, hard, soft, command
// - Full test: interface test, then instrument test
// - Commanded test runs instrument test only
// - Backplane reset line acts as hard reset
// - Commander reset write acts as soft reset
// - Full test start asserts failure line, LED
// - Interface pass releases line; fail keeps it
// - Instrument test follows; failures are recorded
// - Power-on end opens relays unless excluded
// - Commanded test leaves failure line alone
// - Commanded test end restores relay state
// - Supply loss or reset asserts failure line
// - Inhibit releases line unless relay 5V lost
// - Close connects input c to section common
// - Join ties section 1 common to 2..s
// - Open all plus disjoin clears every path
// - One-wire close ties terminal to low wires
`timescale 1ns/1ps
module relay_mux_self_test_reset #(
  parameter int FAIL_W = relay_mux_pkg::DEF_FAIL_W
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Backplane and supply pins
  input wire logic SYSRESET_N_PIN,
  input wire logic SUPPLY_OK_PIN,
  input wire logic RELAY_5V_OK_PIN,
  // Open-drain failure line
  input wire logic SYSFAIL_IN,
  output logic SYSFAIL_OUT,
  output logic SYSFAIL_OE_N,
  // Commander controls
  input wire logic SOFT_RESET_WR,
  input wire logic SYSFAIL_INHIBIT,
  input wire logic SELF_TEST_CMD,
  // Interface test engine
  output logic IF_TEST_START,
  input wire logic IF_TEST_DONE,
  input wire logic IF_TEST_PASS,
  // Instrument test engine
  output logic INST_TEST_START,
  input wire logic INST_TEST_DONE,
  input wire logic [FAIL_W-1:0] INST_TEST_FAIL,
  input wire logic TEST_REL_WR,
  input wire logic [relay_mux_pkg::REL_W-1:0] TEST_REL_VAL,
  // Status
  output logic FAILED_LED,
  output logic PASSED_STATE,
  output logic FAILED_STATE,
  output logic TEST_BUSY,
  output logic [FAIL_W-1:0] FAIL_RECORD,
  // Routing commands
  input wire logic ROUTE_VALID,
  input wire logic [2:0] ROUTE_OP,
  input wire logic [relay_mux_pkg::SECT_W-1:0] ROUTE_SECT,
  input wire logic [relay_mux_pkg::CHAN_W-1:0] ROUTE_CHAN,
  input wire logic RELAY_TYPE_EXCLUDED,
  // Relay drives
  output logic [relay_mux_pkg::PATH_W-1:0] PATH_CLOSE,
  output logic [relay_mux_pkg::NUM_JOIN-1:0] COMMON_JOIN,
  output logic [relay_mux_pkg::NUM_SECT-1:0] ONE_WIRE_PATH,
  output logic [relay_mux_pkg::NUM_SECT-1:0] ONE_WIRE_CFG
);

  // Synchronised pins
  logic sysrst_n_s; // Backplane reset, low active
  logic supply_ok_s; // All supplies present
  logic relay5v_s; // Relay board 5V present

  // Sequencer state
  relay_mux_pkg::seq_state_t state_reg, state_next;
  logic pwr_pend_reg, pwr_pend_next; // Power-up test still owed
  logic pwr_run_reg, pwr_run_next; // Current test came from power-up
  logic cmd_run_reg, cmd_run_next; // Current test came from command
  logic hr_prev_reg, hr_prev_next; // Previous reset line level
  logic if_start_reg, if_start_next;
  logic inst_start_reg, inst_start_next;
  logic led_reg, led_next;
  logic passed_reg, passed_next;
  logic failed_reg, failed_next;
  logic busy_reg, busy_next;
  logic oe_n_reg, oe_n_next;
  logic [FAIL_W-1:0] rec_reg, rec_next;

  // Relay state
  logic [relay_mux_pkg::REL_W-1:0] rel_reg, rel_next; // Live relay drives
  logic [relay_mux_pkg::REL_W-1:0] snap_reg, snap_next; // Pre-test copy
  logic [relay_mux_pkg::NUM_SECT-1:0] cfg_reg, cfg_next; // One-wire sections

  // Decoded events
  logic hr_active; // Backplane reset held
  logic hr_release; // Backplane reset just released
  logic full_go; // Start of a full test
  logic cmd_go; // Start of a commanded test
  logic inst_end; // Instrument test finished
  logic want_fail; // Something calls for the failure line

  // Pin synchronisers
  in_sync3 #(.RESET_VAL(1'b1)) u_sync_rst (
    .clk(CLK), .reset_n(RESET_N), .async_in(SYSRESET_N_PIN), .sync_out(sysrst_n_s));
  in_sync3 #(.RESET_VAL(1'b1)) u_sync_sup (
    .clk(CLK), .reset_n(RESET_N), .async_in(SUPPLY_OK_PIN), .sync_out(supply_ok_s));
  in_sync3 #(.RESET_VAL(1'b1)) u_sync_r5v (
    .clk(CLK), .reset_n(RESET_N), .async_in(RELAY_5V_OK_PIN), .sync_out(relay5v_s));

  // Event decode
  always_comb begin
    hr_active = ~sysrst_n_s;
    hr_release = sysrst_n_s & ~hr_prev_reg;
    full_go = ~hr_active & (SOFT_RESET_WR | hr_release | pwr_pend_reg);
    cmd_go = ~full_go & ~hr_active & SELF_TEST_CMD & (state_reg == relay_mux_pkg::ST_IDLE);
    inst_end = (state_reg == relay_mux_pkg::ST_INST) & INST_TEST_DONE;
  end

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    pwr_pend_next = pwr_pend_reg;
    pwr_run_next = pwr_run_reg;
    cmd_run_next = cmd_run_reg;
    hr_prev_next = sysrst_n_s;
    if_start_next = 1'b0;
    inst_start_next = 1'b0;
    led_next = led_reg;
    passed_next = passed_reg;
    failed_next = failed_reg;
    rec_next = rec_reg;
    if (hr_active) begin
      // Reset held: park and show failure
      state_next = relay_mux_pkg::ST_IDLE;
      led_next = 1'b1;
      passed_next = 1'b0;
      cmd_run_next = 1'b0;
    end else if (full_go) begin
      // Full test always opens with interface test
      state_next = relay_mux_pkg::ST_IF;
      if_start_next = 1'b1;
      led_next = 1'b1;
      passed_next = 1'b0;
      failed_next = 1'b0;
      pwr_run_next = pwr_pend_reg;
      pwr_pend_next = 1'b0;
      cmd_run_next = 1'b0;
    end else begin
      case (state_reg)
        relay_mux_pkg::ST_IDLE: begin
          // Command skips the interface test
          if (cmd_go) begin
            state_next = relay_mux_pkg::ST_INST;
            inst_start_next = 1'b1;
            rec_next = {FAIL_W{1'b0}};
            cmd_run_next = 1'b1;
            pwr_run_next = 1'b0;
          end
        end
        relay_mux_pkg::ST_IF: begin
          // Interface verdict, then instrument test
          if (IF_TEST_DONE) begin
            passed_next = IF_TEST_PASS;
            failed_next = ~IF_TEST_PASS;
            led_next = ~IF_TEST_PASS;
            state_next = relay_mux_pkg::ST_INST;
            inst_start_next = 1'b1;
            rec_next = {FAIL_W{1'b0}};
          end
        end
        relay_mux_pkg::ST_INST: begin
          // Record failures of every unit
          if (INST_TEST_DONE) begin
            rec_next = rec_reg | INST_TEST_FAIL;
            state_next = relay_mux_pkg::ST_IDLE;
          end
        end
        default: begin
          state_next = relay_mux_pkg::ST_IDLE;
        end
      endcase
    end
    busy_next = (state_next != relay_mux_pkg::ST_IDLE);
    // Failure line: full test, failed state, reset, supply loss
    want_fail = ((state_reg == relay_mux_pkg::ST_IF) & ~cmd_run_reg) | failed_reg
              | hr_active | pwr_pend_reg | ~supply_ok_s | ~relay5v_s;
    oe_n_next = ~(want_fail & ~(SYSFAIL_INHIBIT & relay5v_s));
  end

  // Sequencer registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= relay_mux_pkg::ST_IDLE;
      pwr_pend_reg <= 1'b1;
      pwr_run_reg <= 1'b0;
      cmd_run_reg <= 1'b0;
      hr_prev_reg <= 1'b1;
      if_start_reg <= 1'b0;
      inst_start_reg <= 1'b0;
      led_reg <= 1'b1;
      passed_reg <= 1'b0;
      failed_reg <= 1'b0;
      busy_reg <= 1'b0;
      oe_n_reg <= 1'b0;
      rec_reg <= {FAIL_W{1'b0}};
    end else begin
      state_reg <= state_next;
      pwr_pend_reg <= pwr_pend_next;
      pwr_run_reg <= pwr_run_next;
      cmd_run_reg <= cmd_run_next;
      hr_prev_reg <= hr_prev_next;
      if_start_reg <= if_start_next;
      inst_start_reg <= inst_start_next;
      led_reg <= led_next;
      passed_reg <= passed_next;
      failed_reg <= failed_next;
      busy_reg <= busy_next;
      oe_n_reg <= oe_n_next;
      rec_reg <= rec_next;
    end
  end

  // Relay next state
  always_comb begin
    int sect;
    int chan;
    sect = int'(ROUTE_SECT);
    chan = int'(ROUTE_CHAN);
    rel_next = rel_reg;
    snap_next = snap_reg;
    cfg_next = cfg_reg;
    if (cmd_go) begin
      snap_next = rel_reg;
    end
    if (inst_end & cmd_run_reg) begin
      rel_next = snap_reg;
    end else if (inst_end & pwr_run_reg & ~RELAY_TYPE_EXCLUDED) begin
      rel_next = relay_mux_pkg::REL_RESET;
    end else if (TEST_REL_WR & (state_reg == relay_mux_pkg::ST_INST)) begin
      rel_next = TEST_REL_VAL;
    end else if (ROUTE_VALID & (state_reg == relay_mux_pkg::ST_IDLE) & ~full_go) begin
      case (ROUTE_OP)
        relay_mux_pkg::OP_CLOSE: begin
          // Four-wire or one-wire close
          if (sect >= 1 && sect <= relay_mux_pkg::NUM_SECT
              && chan >= 1 && chan <= relay_mux_pkg::NUM_CHAN) begin
            if (cfg_reg[sect-1] && chan == 1) begin
              rel_next[relay_mux_pkg::OWP_LSB + sect - 1] = 1'b1;
            end else begin
              rel_next[relay_mux_pkg::PATH_LSB + (sect-1)*relay_mux_pkg::NUM_CHAN
                       + chan - 1] = 1'b1;
            end
          end
        end
        relay_mux_pkg::OP_OPEN_ALL: begin
          // Open paths, keep joins
          rel_next[relay_mux_pkg::JOIN_LSB-1:relay_mux_pkg::PATH_LSB] = '0;
          rel_next[relay_mux_pkg::REL_W-1:relay_mux_pkg::OWP_LSB] = '0;
        end
        relay_mux_pkg::OP_JOIN: begin
          // Section 1 common to sections 2..s
          for (int j = 0; j < relay_mux_pkg::NUM_JOIN; j++) begin
            if (j + 2 <= sect && sect <= relay_mux_pkg::NUM_SECT) begin
              rel_next[relay_mux_pkg::JOIN_LSB + j] = 1'b1;
            end
          end
        end
        relay_mux_pkg::OP_DISJOIN: begin
          // Separate all adjacent commons
          rel_next[relay_mux_pkg::OWP_LSB-1:relay_mux_pkg::JOIN_LSB] = '0;
        end
        relay_mux_pkg::OP_ONE_WIRE_CFG: begin
          // Put section into one-wire mode
          if (sect >= 1 && sect <= relay_mux_pkg::NUM_SECT) begin
            cfg_next[sect-1] = 1'b1;
          end
        end
        default: begin
          rel_next = rel_reg;
        end
      endcase
    end
  end

  // Relay registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rel_reg <= relay_mux_pkg::REL_RESET;
      snap_reg <= relay_mux_pkg::REL_RESET;
      cfg_reg <= relay_mux_pkg::CFG_RESET;
    end else begin
      rel_reg <= rel_next;
      snap_reg <= snap_next;
      cfg_reg <= cfg_next;
    end
  end

  // Outputs, each from a register except SYSFAIL_OUT, which is tied low
  assign SYSFAIL_OUT = 1'b0;
  assign SYSFAIL_OE_N = oe_n_reg;
  assign IF_TEST_START = if_start_reg;
  assign INST_TEST_START = inst_start_reg;
  assign FAILED_LED = led_reg;
  assign PASSED_STATE = passed_reg;
  assign FAILED_STATE = failed_reg;
  assign TEST_BUSY = busy_reg;
  assign FAIL_RECORD = rec_reg;
  assign PATH_CLOSE = rel_reg[relay_mux_pkg::JOIN_LSB-1:relay_mux_pkg::PATH_LSB];
  assign COMMON_JOIN = rel_reg[relay_mux_pkg::OWP_LSB-1:relay_mux_pkg::JOIN_LSB];
  assign ONE_WIRE_PATH = rel_reg[relay_mux_pkg::REL_W-1:relay_mux_pkg::OWP_LSB];
  assign ONE_WIRE_CFG = cfg_reg;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_full_if_first: assert property (full_go |=> IF_TEST_START && !INST_TEST_START)
    else $error("full test did not begin with interface test");
  a_cmd_inst_only: assert property (cmd_go |=> INST_TEST_START && !IF_TEST_START)
    else $error("commanded test did not run instrument test only");
  a_hard_release: assert property ($rose(sysrst_n_s) |=> IF_TEST_START)
    else $error("hard reset release did not start full test");
  a_soft_reset: assert property (SOFT_RESET_WR && !hr_active |=> IF_TEST_START)
    else $error("soft reset did not start full test");
  a_full_fail_line: assert property (full_go ##1 !SYSFAIL_INHIBIT |=> !SYSFAIL_OE_N)
    else $error("failure line not asserted at full test start");
  a_if_pass_rel: assert property (state_reg == relay_mux_pkg::ST_IF && IF_TEST_DONE
    && IF_TEST_PASS && !full_go && !hr_active |=> PASSED_STATE && !FAILED_LED)
    else $error("interface pass not reflected");
  a_if_then_inst: assert property (state_reg == relay_mux_pkg::ST_IF && IF_TEST_DONE
    && !full_go && !hr_active |=> INST_TEST_START)
    else $error("instrument test did not follow interface test");
  a_pwr_open: assert property (inst_end && pwr_run_reg && !RELAY_TYPE_EXCLUDED && !full_go
    && !hr_active |=> rel_reg == relay_mux_pkg::REL_RESET)
    else $error("relays not opened after power-on test");
  a_cmd_quiet: assert property (cmd_run_reg && !failed_reg && supply_ok_s && relay5v_s
    && !hr_active && !pwr_pend_reg |=> SYSFAIL_OE_N)
    else $error("failure line asserted in commanded test");
  a_cmd_restore: assert property (inst_end && cmd_run_reg && !full_go && !hr_active
    |=> rel_reg == $past(snap_reg))
    else $error("relay state not restored after commanded test");
  a_supply_loss: assert property (!supply_ok_s && !SYSFAIL_INHIBIT |=> !SYSFAIL_OE_N)
    else $error("supply loss did not assert failure line");
  a_inhibit_line: assert property (SYSFAIL_INHIBIT && relay5v_s |=> SYSFAIL_OE_N)
    else $error("inhibit did not release failure line");

endmodule // relay_mux_self_test_reset

// >>> sim/commander_model.sv
// Purpose: Commander, resource manager and test engine model
// Assumes: Engines answer a fixed count of cycles after each start pulse
// Notes: Verdict and relay lines show inverted values outside their pulse
`timescale 1ns/1ps
module commander_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench requests
  input wire logic soft_req,
  input wire logic cmd_req,
  input wire logic inh_soft,
  input wire logic rm_en,
  input wire logic if_pass,
  input wire logic [1:0] inst_fail,
  input wire logic [relay_mux_pkg::REL_W-1:0] rel_val,
  // Device side
  input wire logic sysfail_oe_n,
  input wire logic if_start,
  input wire logic inst_start,
  output logic soft_wr,
  output logic test_cmd,
  output logic inhibit,
  output logic if_done,
  output logic if_verdict,
  output logic inst_done,
  output logic [1:0] inst_fail_out,
  output logic rel_wr,
  output logic [relay_mux_pkg::REL_W-1:0] rel_out
);
  logic [3:0] if_cnt; // Interface engine countdown
  logic [3:0] inst_cnt; // Instrument engine countdown
  // Values only valid beside their pulse
  assign if_verdict = if_done ? if_pass : ~if_pass;
  assign inst_fail_out = inst_done ? inst_fail : ~inst_fail;
  assign rel_out = rel_wr ? rel_val : ~rel_val;
  // Commander, resource manager and engines
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {soft_wr, test_cmd, inhibit, if_done, inst_done, rel_wr} <= 6'h00;
      if_cnt <= 4'h0;
      inst_cnt <= 4'h0;
    end else begin
      soft_wr <= soft_req;
      test_cmd <= cmd_req;
      // Inhibit with the reset write, or on seeing the line asserted
      if (soft_req && inh_soft) inhibit <= 1'b1;
      else if (rm_en && !sysfail_oe_n) inhibit <= 1'b1;
      else if (!rm_en && !inh_soft) inhibit <= 1'b0;
      if_cnt <= if_start ? 4'h6 : (if_cnt != 4'h0) ? if_cnt - 4'h1 : 4'h0;
      inst_cnt <= inst_start ? 4'h9 : (inst_cnt != 4'h0) ? inst_cnt - 4'h1 : 4'h0;
      if_done <= (if_cnt == 4'h1);
      inst_done <= (inst_cnt == 4'h1);
      rel_wr <= (inst_cnt == 4'h5);
    end
  end
endmodule // commander_model

// >>> sim/tb.sv
// Purpose: Self-checking bench for the self-test and relay routing block
// Assumes: commander_model stands for commander and test engines
// Notes: Relay state is predicted by a bench model after every routing step
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0; // Bench clock
  logic reset_n = 1'b0; // Block reset
  logic sysreset_n = 1'b1, supply_ok = 1'b1, relay5v_ok = 1'b1; // Pins
  logic soft_req = 1'b0, cmd_req = 1'b0, inh_soft = 1'b0, rm_en = 1'b0; // Requests
  logic if_pass = 1'b1; // Interface verdict
  logic [1:0] inst_fail = 2'h0; // Instrument failures
  logic [relay_mux_pkg::REL_W-1:0] rel_val = '1, exp_rel = '0, snap; // Relay values
  logic rel_excl = 1'b0; // Excluded relay board type
  logic [5:0] exp_cfg = 6'h00; // Expected one-wire config
  logic route_valid = 1'b0; // Routing strobe
  logic [2:0] route_op = 3'h0, route_sect = 3'h0;
  logic [3:0] route_chan = 4'h0;
  logic sysfail_oe_n, sysfail_out, soft_wr, test_cmd, inhibit, if_done, if_verdict;
  logic inst_done, rel_wr, if_start, inst_start, failed_led, passed_st, failed_st, busy;
  logic [1:0] fail_out, fail_rec;
  logic [relay_mux_pkg::REL_W-1:0] rel_out;
  logic [59:0] path;
  logic [4:0] join_v;
  logic [5:0] owp, owc;
  logic seen_if = 1'b0, seen_low = 1'b0; // Watch flags
  logic [15:0] rnd = 16'h0003; // Random state
  int bad_count = 0, comparisons = 0, cycles = 0;
  wire sysfail_wire = sysfail_oe_n ? 1'b1 : sysfail_out; // Pulled-up line

  relay_mux_self_test_reset relay_mux_self_test_reset_inst (
    .CLK(clk), .RESET_N(reset_n), .SYSRESET_N_PIN(sysreset_n), .SUPPLY_OK_PIN(supply_ok),
    .RELAY_5V_OK_PIN(relay5v_ok), .SYSFAIL_IN(sysfail_wire), .SYSFAIL_OUT(sysfail_out),
    .SYSFAIL_OE_N(sysfail_oe_n), .SOFT_RESET_WR(soft_wr), .SYSFAIL_INHIBIT(inhibit),
    .SELF_TEST_CMD(test_cmd), .IF_TEST_START(if_start), .IF_TEST_DONE(if_done),
    .IF_TEST_PASS(if_verdict), .INST_TEST_START(inst_start), .INST_TEST_DONE(inst_done),
    .INST_TEST_FAIL(fail_out), .TEST_REL_WR(rel_wr), .TEST_REL_VAL(rel_out),
    .FAILED_LED(failed_led), .PASSED_STATE(passed_st), .FAILED_STATE(failed_st),
    .TEST_BUSY(busy), .FAIL_RECORD(fail_rec), .ROUTE_VALID(route_valid),
    .ROUTE_OP(route_op), .ROUTE_SECT(route_sect), .ROUTE_CHAN(route_chan),
    .RELAY_TYPE_EXCLUDED(rel_excl), .PATH_CLOSE(path), .COMMON_JOIN(join_v),
    .ONE_WIRE_PATH(owp), .ONE_WIRE_CFG(owc));

  commander_model commander_model_inst (
    .clk(clk), .reset_n(reset_n), .soft_req(soft_req), .cmd_req(cmd_req),
    .inh_soft(inh_soft), .rm_en(rm_en), .if_pass(if_pass), .inst_fail(inst_fail),
    .rel_val(rel_val), .sysfail_oe_n(sysfail_oe_n), .if_start(if_start),
    .inst_start(inst_start), .soft_wr(soft_wr), .test_cmd(test_cmd), .inhibit(inhibit),
    .if_done(if_done), .if_verdict(if_verdict), .inst_done(inst_done),
    .inst_fail_out(fail_out), .rel_wr(rel_wr), .rel_out(rel_out));

  // Clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait: 0 interface start, 1 instrument start, 2 idle
  task automatic wait_for(input int k);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 300 && !hit; i++) begin
      cyc(1);
      seen_if |= if_start;
      seen_low |= !sysfail_oe_n;
      hit = (k == 0) ? if_start : (k == 1) ? inst_start : !busy;
    end
    chk(hit, 1'b1);
  endtask

  // Commander request: 0 soft reset, 1 self-test command
  task automatic pulse_req(input int k, input logic pass, input logic inh);
    @(posedge clk);
    rnd = lfsr(rnd);
    rel_val <= {rnd[6:0], rnd, rnd, rnd, rnd};
    inst_fail <= rnd[1:0];
    if_pass <= pass;
    inh_soft <= inh;
    if (k == 0) soft_req <= 1'b1;
    else cmd_req <= 1'b1;
    @(posedge clk);
    soft_req <= 1'b0;
    cmd_req <= 1'b0;
  endtask

  // Routing command with model update
  task automatic route(input int op, input int s, input int c);
    @(posedge clk);
    route_valid <= 1'b1;
    route_op <= 3'(op);
    route_sect <= 3'(s);
    route_chan <= 4'(c);
    @(posedge clk);
    route_valid <= 1'b0;
    if (op == 0 && s >= 1 && s <= 6 && c >= 1 && c <= 10) begin
      if (exp_cfg[s-1] && c == 1) exp_rel[65+s-1] = 1'b1;
      else exp_rel[(s-1)*10+c-1] = 1'b1;
    end
    if (op == 1) exp_rel[70:0] = {6'h00, exp_rel[64:60], 60'h0};
    if (op == 2) for (int j = 0; j < s - 1; j++) exp_rel[60+j] = 1'b1;
    if (op == 3) exp_rel[64:60] = 5'h00;
    if (op == 4) exp_cfg[s-1] = 1'b1;
    cyc(1);
    chk({owp, join_v, path}, exp_rel);
    chk(owc, exp_cfg);
  endtask

  initial begin
    // Power-up test
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    wait_for(0);
    chk(failed_led, 1'b1);
    cyc(2);
    chk(sysfail_oe_n, 1'b0);
    wait_for(1);
    chk({passed_st, failed_led}, 2'h2);
    wait_for(2);
    chk(fail_rec, inst_fail);
    chk({owp, join_v, path}, 71'h0);
    cyc(4);
    chk(sysfail_oe_n, 1'b1);
    $display("test power_up done");
    // Refused routes, then every close and join
    route(0, 7, 1);
    route(0, 1, 11);
    route(0, 0, 3);
    route(5, 1, 1);
    for (int s = 1; s <= 6; s++) for (int c = 1; c <= 10; c++) route(0, s, c);
    for (int s = 2; s <= 6; s++) route(2, s, 0);
    $display("test routing done");
    // Commanded test with relays set
    snap = exp_rel;
    seen_if = 1'b0;
    seen_low = 1'b0;
    pulse_req(1, 1'b1, 1'b0);
    wait_for(1);
    wait_for(2);
    chk(seen_if, 1'b0);
    chk(seen_low, 1'b0);
    chk({owp, join_v, path}, snap);
    chk(fail_rec, inst_fail);
    $display("test commanded done");
    // Open all, disjoin, one-wire closes
    route(1, 1, 1);
    route(3, 1, 1);
    for (int s = 1; s <= 6; s++) route(4, s, 1);
    for (int s = 1; s <= 6; s++) route(0, s, 1);
    $display("test one_wire done");
    // Soft reset with failing interface test
    pulse_req(0, 1'b0, 1'b0);
    wait_for(0);
    chk(failed_led, 1'b1);
    cyc(2);
    chk(sysfail_oe_n, 1'b0);
    wait_for(1);
    chk({passed_st, failed_st}, 2'h1);
    wait_for(2);
    cyc(4);
    chk(sysfail_oe_n, 1'b0);
    chk(sysfail_wire, 1'b0);
    @(posedge clk);
    rm_en <= 1'b1;
    cyc(6);
    chk(sysfail_oe_n, 1'b1);
    @(posedge clk);
    relay5v_ok <= 1'b0;
    cyc(10);
    chk(sysfail_oe_n, 1'b0);
    @(posedge clk);
    relay5v_ok <= 1'b1;
    cyc(10);
    $display("test soft_fail done");
    // Soft reset with inhibit set alongside
    seen_low = 1'b0;
    pulse_req(0, 1'b1, 1'b1);
    @(posedge clk);
    rm_en <= 1'b0;
    wait_for(1);
    wait_for(2);
    chk(seen_low, 1'b0);
    chk(passed_st, 1'b1);
    @(posedge clk);
    inh_soft <= 1'b0;
    cyc(4);
    chk(sysfail_oe_n, 1'b1);
    $display("test soft_inhibit done");
    // Supply loss then hard reset
    @(posedge clk);
    supply_ok <= 1'b0;
    cyc(10);
    chk(sysfail_oe_n, 1'b0);
    @(posedge clk);
    supply_ok <= 1'b1;
    sysreset_n <= 1'b0;
    cyc(10);
    chk({sysfail_oe_n, failed_led}, 2'h1);
    @(posedge clk);
    sysreset_n <= 1'b1;
    wait_for(0);
    wait_for(1);
    wait_for(2);
    cyc(4);
    chk({passed_st, sysfail_oe_n}, 2'h3);
    $display("test hard_reset done");
    // Block reset while idle, with the excluded relay board type
    @(posedge clk);
    reset_n <= 1'b0;
    rel_excl <= 1'b1;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    wait_for(0);
    wait_for(1);
    wait_for(2);
    chk({owp, join_v, path}, rel_val);
    chk(fail_rec, inst_fail);
    chk(owc, 6'h00);
    $display("test excluded_reset done");
    complete_run();
  end
endmodule // tb
